/* cas_lane.sv */
`timescale 1ns/1ns
`default_nettype none
module cas_lane #(
	parameter int W = 32,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// staging control
	input wire logic wr,
	input wire logic commit,
	input wire logic [W-1:0] wdata,
	// staged and active values
	output logic [W-1:0] pend_q,
	output logic [W-1:0] act_q
);
	logic [W-1:0] pend_d;
	logic [W-1:0] act_d;

	// write stages, commit makes it active
	always_comb
	begin
		pend_d = wr ? wdata : pend_q;
		act_d = act_q;
		if (commit)
			act_d = pend_d;
	end

	// register the lane
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pend_q <= RST_VAL;
			act_q <= RST_VAL;
		end
		else
		begin
			pend_q <= pend_d;
			act_q <= act_d;
		end
	end
endmodule // cas_lane
`default_nettype wire

/* cas_pkg.sv */
package cas_pkg;
	localparam int CTX_W = 32;
	localparam int EPOCH_W = 8;
	localparam int NLANE = 3;
	// lanes of staged context
	localparam int LANE_CTX = 0;
	localparam int LANE_MSR = 1;
	localparam int LANE_DBG = 2;
	// machine state bit positions
	localparam int MSR_ME_BIT = 12;
	localparam int MSR_DE_BIT = 9;
	// register offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_CTX = 12'h008;
	localparam logic [11:0] A_MSR = 12'h00c;
	localparam logic [11:0] A_DBG = 12'h010;
	localparam logic [11:0] A_COUNT = 12'h014;
	// control fields
	localparam int CTRL_STRICT_BIT = 0;
	localparam int CTRL_CLRCNT_BIT = 1;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
	// status fields above the state code
	localparam int STAT_DWAIT_BIT = 3;
	localparam int STAT_DSYNC_BIT = 4;
	localparam int STAT_STAGED_BIT = 5;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CTX_RST = 32'h0000_0000;
	localparam logic [7:0] EPOCH_RST = 8'h00;
	// dispatched instruction classes
	typedef enum logic [2:0] {
		K_NORMAL, K_ALT_IMM, K_ALT_DEF, K_MSR_WR,
		K_CSI, K_MEM_BAR, K_DBG_WR, K_TLB_OP
	} cas_kind_t;
	typedef enum logic [2:0] {
		S_IDLE, S_DRAIN_CSI, S_DRAIN_MSR, S_DRAIN_BAR, S_FLUSH
	} cas_state_t;
endpackage

/* cas_seq.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cas_seq (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// instruction stream from dispatch
	input wire logic INSN_VALID,
	input wire cas_pkg::cas_kind_t INSN_KIND,
	input wire logic [cas_pkg::CTX_W-1:0] INSN_DATA,
	output logic DISPATCH_HOLD,
	// core progress
	input wire logic OLDER_IDLE,
	input wire logic LOCK_BUSY,
	input wire logic STASH_BUSY,
	input wire logic IRQ_REQ,
	output logic IRQ_ACK,
	// established context
	output logic FETCH_FLUSH,
	output logic [cas_pkg::CTX_W-1:0] ACTIVE_CTX,
	output logic [cas_pkg::CTX_W-1:0] ACTIVE_MSR,
	output logic [cas_pkg::CTX_W-1:0] DEBUG_CFG,
	output logic MCHK_ENABLE,
	output logic [cas_pkg::EPOCH_W-1:0] TRANS_EPOCH
);
	import cas_pkg::*;

	// sequencer state
	cas_state_t st_q, st_d;
	logic hold_q, hold_d;
	logic flush_q, flush_d;
	logic ack_q, ack_d;
	logic irq_q, irq_d;
	logic mchk_q, mchk_d;
	logic dbg_wait_q, dbg_wait_d;
	logic dbg_sync_q, dbg_sync_d;
	logic [CTX_W-1:0] msr_hold_q, msr_hold_d;
	logic [EPOCH_W-1:0] epoch_q, epoch_d;
	logic [EPOCH_W-1:0] epoch_pend_q, epoch_pend_d;

	// register file
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;

	// lane wiring
	logic [NLANE-1:0] lane_wr;
	logic [NLANE-1:0] lane_cm;
	logic [CTX_W-1:0] lane_wd;
	logic [CTX_W-1:0] lane_pend [NLANE];
	logic [CTX_W-1:0] lane_act [NLANE];

	// decoded strobes
	logic [31:0] status_w;
	logic take;
	logic apb_acc;
	logic apb_wr;
	logic strict;
	logic clr_cnt;
	logic ser_done;

	// register address decode
	function automatic logic reg_hit(input logic [11:0] a);
		case (a)
			A_CTRL, A_STATUS, A_CTX, A_MSR, A_DBG, A_COUNT:
				reg_hit = 1'b1;
			default:
				reg_hit = 1'b0;
		endcase
	endfunction

	// staged context lanes
	genvar g;
	generate
		for (g = 0; g < NLANE; g++)
		begin : g_lane
			cas_lane #(
				.W(CTX_W),
				.RST_VAL(CTX_RST)
			) u_lane (
				.clk(CLK),
				.rst(RST),
				.wr(lane_wr[g]),
				.commit(lane_cm[g]),
				.wdata(lane_wd),
				.pend_q(lane_pend[g]),
				.act_q(lane_act[g])
			);
		end
	endgenerate

	// apb access phase and write strobe
	assign apb_acc = PSEL & PENABLE;
	assign apb_wr = apb_acc & PWRITE & ready_q;
	assign strict = ctrl_q[CTRL_STRICT_BIT];
	assign clr_cnt = ctrl_q[CTRL_CLRCNT_BIT];

	// instruction taken only when not held and no interrupt
	assign take = INSN_VALID & ~hold_q & ~IRQ_REQ;
	assign lane_wd = (st_q == S_DRAIN_MSR) ? msr_hold_q : INSN_DATA;

	// status word fields
	always_comb
	begin
		status_w = '0;
		status_w[$bits(cas_state_t)-1:0] = st_q;
		status_w[STAT_DWAIT_BIT] = dbg_wait_q;
		status_w[STAT_DSYNC_BIT] = dbg_sync_q;
		status_w[STAT_STAGED_BIT] = lane_pend[LANE_CTX] != lane_act[LANE_CTX];
	end

	// sequencer next state
	always_comb
	begin
		st_d = st_q;
		flush_d = 1'b0;
		ack_d = 1'b0;
		irq_d = irq_q;
		mchk_d = mchk_q;
		dbg_wait_d = dbg_wait_q;
		dbg_sync_d = dbg_sync_q;
		msr_hold_d = msr_hold_q;
		epoch_d = epoch_q;
		epoch_pend_d = epoch_pend_q;
		lane_wr = '0;
		lane_cm = '0;
		ser_done = 1'b0;
		case (st_q)
			S_IDLE:
			begin
				if (IRQ_REQ)
				begin
					irq_d = 1'b1;
					st_d = S_DRAIN_CSI;
				end
				else if (take)
				begin
					case (INSN_KIND)
						K_NORMAL:
							st_d = S_IDLE;
						K_ALT_IMM:
						begin
							lane_wr[LANE_CTX] = 1'b1;
							if (strict)
								st_d = S_DRAIN_CSI;
							else
								lane_cm[LANE_CTX] = 1'b1;
						end
						K_ALT_DEF:
							lane_wr[LANE_CTX] = 1'b1;
						K_TLB_OP:
							epoch_pend_d = epoch_pend_q + 1'b1;
						K_DBG_WR:
						begin
							lane_wr[LANE_DBG] = 1'b1;
							dbg_wait_d = 1'b1;
							dbg_sync_d = 1'b0;
						end
						K_MSR_WR:
						begin
							msr_hold_d = INSN_DATA;
							st_d = S_DRAIN_MSR;
						end
						K_CSI:
							st_d = S_DRAIN_CSI;
						K_MEM_BAR:
							st_d = S_DRAIN_BAR;
						default:
							st_d = S_IDLE;
					endcase
				end
			end
			S_DRAIN_CSI:
			begin
				// older work completes in old context first
				if (OLDER_IDLE)
				begin
					lane_cm[LANE_CTX] = 1'b1;
					lane_cm[LANE_MSR] = 1'b1;
					epoch_d = epoch_pend_q;
					mchk_d = lane_pend[LANE_MSR][MSR_ME_BIT];
					dbg_sync_d = dbg_wait_q;
					flush_d = 1'b1;
					ack_d = irq_q;
					irq_d = 1'b0;
					ser_done = 1'b1;
					st_d = S_FLUSH;
				end
			end
			S_DRAIN_MSR:
			begin
				if (OLDER_IDLE)
				begin
					lane_wr[LANE_MSR] = 1'b1;
					// debug rise after a serializing op applies debug changes
					if (dbg_wait_q && dbg_sync_q &&
						!lane_pend[LANE_MSR][MSR_DE_BIT] &&
						msr_hold_q[MSR_DE_BIT])
					begin
						lane_cm[LANE_DBG] = 1'b1;
						dbg_wait_d = 1'b0;
						dbg_sync_d = 1'b0;
					end
					st_d = S_IDLE;
				end
			end
			S_DRAIN_BAR:
			begin
				// barrier ends after locking and stashing finish
				if (OLDER_IDLE && !LOCK_BUSY && !STASH_BUSY)
					st_d = S_IDLE;
			end
			S_FLUSH:
				st_d = S_IDLE;
			default:
				st_d = S_IDLE;
		endcase
		hold_d = (st_d != S_IDLE);
	end

	// sequencer registers
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			st_q <= S_IDLE;
			hold_q <= 1'b0;
			flush_q <= 1'b0;
			ack_q <= 1'b0;
			irq_q <= 1'b0;
			mchk_q <= 1'b0;
			dbg_wait_q <= 1'b0;
			dbg_sync_q <= 1'b0;
			msr_hold_q <= CTX_RST;
			epoch_q <= EPOCH_RST;
			epoch_pend_q <= EPOCH_RST;
		end
		else
		begin
			st_q <= st_d;
			hold_q <= hold_d;
			flush_q <= flush_d;
			ack_q <= ack_d;
			irq_q <= irq_d;
			mchk_q <= mchk_d;
			dbg_wait_q <= dbg_wait_d;
			dbg_sync_q <= dbg_sync_d;
			msr_hold_q <= msr_hold_d;
			epoch_q <= epoch_d;
			epoch_pend_q <= epoch_pend_d;
		end
	end

	// register file and apb answer
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (clr_cnt)
			ctrl_d[CTRL_CLRCNT_BIT] = 1'b0; // self clearing
		if (apb_wr && PADDR == A_CTRL)
			ctrl_d = PWDATA & CTRL_WMASK;
		ready_d = apb_acc & ~ready_q;
		err_d = apb_acc & ~ready_q & ~reg_hit(PADDR);
		rdata_d = '0;
		if (apb_acc && !ready_q && !PWRITE)
		begin
			case (PADDR)
				A_CTRL: rdata_d = ctrl_q;
				A_STATUS: rdata_d = status_w;
				A_CTX: rdata_d = lane_act[LANE_CTX];
				A_MSR: rdata_d = lane_pend[LANE_MSR];
				A_DBG: rdata_d = lane_act[LANE_DBG];
				A_COUNT: rdata_d = cnt_q;
				default: rdata_d = '0;
			endcase
		end
	end

	// serialization counter, a serialization in a clear cycle counts from zero
	always_comb
	begin
		cnt_d = cnt_q;
		if (clr_cnt)
			cnt_d = '0;
		if (ser_done)
			cnt_d = cnt_d + 32'h0000_0001;
	end

	// serialization counter flop
	always_ff @(posedge CLK)
	begin
		if (RST)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// register file flops
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ctrl_q <= CTRL_RST;
			rdata_q <= '0;
			ready_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
		end
	end

	// outputs straight from flops
	assign PRDATA = rdata_q;
	assign PREADY = ready_q;
	assign PSLVERR = err_q;
	assign DISPATCH_HOLD = hold_q;
	assign IRQ_ACK = ack_q;
	assign FETCH_FLUSH = flush_q;
	assign ACTIVE_CTX = lane_act[LANE_CTX];
	assign ACTIVE_MSR = lane_act[LANE_MSR];
	assign DEBUG_CFG = lane_act[LANE_DBG];
	assign MCHK_ENABLE = mchk_q;
	assign TRANS_EPOCH = epoch_q;
endmodule // cas_seq
`default_nettype wire

/* cas_seq_props.sv */
`timescale 1ns/1ns
`default_nettype none
module cas_seq_props import cas_pkg::*; (
	// apb side
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// dispatch side
	input wire logic INSN_VALID,
	input wire cas_kind_t INSN_KIND,
	input wire logic DISPATCH_HOLD,
	input wire logic OLDER_IDLE,
	input wire logic IRQ_REQ,
	input wire logic IRQ_ACK,
	// established context
	input wire logic FETCH_FLUSH,
	input wire logic [CTX_W-1:0] ACTIVE_CTX,
	input wire logic [CTX_W-1:0] ACTIVE_MSR,
	input wire logic [CTX_W-1:0] DEBUG_CFG,
	input wire logic MCHK_ENABLE,
	input wire logic [EPOCH_W-1:0] TRANS_EPOCH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// serializing op taken, then drain with older work idle
	sequence csi_go;
		INSN_VALID && !DISPATCH_HOLD && !IRQ_REQ && INSN_KIND == K_CSI
		##1 DISPATCH_HOLD && OLDER_IDLE;
	endsequence
	a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY
		##1 !PREADY) else $error("apb answer timing wrong");
	a_err_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_csi_flush: assert property (csi_go |=> FETCH_FLUSH && DISPATCH_HOLD
		##1 !DISPATCH_HOLD) else $error("csi flush timing");
	a_irq_flush: assert property (IRQ_ACK |-> FETCH_FLUSH)
		else $error("irq ack without flush");
	a_flush_drain: assert property (FETCH_FLUSH |-> $past(OLDER_IDLE))
		else $error("flush before drain");
	a_ctx_bound: assert property ($changed(ACTIVE_CTX) |-> FETCH_FLUSH
		|| $past(INSN_VALID && INSN_KIND == K_ALT_IMM))
		else $error("context changed off boundary");
	a_msr_view: assert property ($changed(ACTIVE_MSR) |-> FETCH_FLUSH)
		else $error("fetch state changed off flush");
	a_mchk_csi: assert property ($changed(MCHK_ENABLE) |-> FETCH_FLUSH)
		else $error("machine check enable off flush");
	a_epoch_csi: assert property ($changed(TRANS_EPOCH) |-> FETCH_FLUSH)
		else $error("epoch changed off flush");
	a_dbg_commit: assert property ($changed(DEBUG_CFG)
		|-> $fell(DISPATCH_HOLD)) else $error("debug config off commit");
endmodule // cas_seq_props
bind cas_seq cas_seq_props cas_seq_props_inst (.CLK(CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.INSN_VALID(INSN_VALID), .INSN_KIND(INSN_KIND),
	.DISPATCH_HOLD(DISPATCH_HOLD), .OLDER_IDLE(OLDER_IDLE),
	.IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK), .FETCH_FLUSH(FETCH_FLUSH),
	.ACTIVE_CTX(ACTIVE_CTX), .ACTIVE_MSR(ACTIVE_MSR),
	.DEBUG_CFG(DEBUG_CFG), .MCHK_ENABLE(MCHK_ENABLE),
	.TRANS_EPOCH(TRANS_EPOCH));
`default_nettype wire

/* tb_cas_seq.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module tb_cas_seq import cas_pkg::*;;
	logic clk, rst, psel, penable, pwrite, valid, oi, lck, stb, irq;
	logic pready, pslverr, hold, irq_ack, flush, mce, fl, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, data, actx, dcfg, rd, amsr;
	logic [7:0] epoch;
	cas_kind_t kind;
	int n_errors = 0;
	int compares = 0;
	cas_seq cas_seq_inst (.CLK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.INSN_VALID(valid), .INSN_KIND(kind), .INSN_DATA(data),
		.DISPATCH_HOLD(hold), .OLDER_IDLE(oi), .LOCK_BUSY(lck),
		.STASH_BUSY(stb), .IRQ_REQ(irq), .IRQ_ACK(irq_ack),
		.FETCH_FLUSH(flush), .ACTIVE_CTX(actx), .ACTIVE_MSR(amsr),
		.DEBUG_CFG(dcfg), .MCHK_ENABLE(mce), .TRANS_EPOCH(epoch));
	// clock
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// one apb transfer, read data and error kept in rd and er
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (!pready);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// dispatch one instruction, wait out any drain, note flush
	task automatic ins(input cas_kind_t k, input logic [31:0] d);
		@(posedge clk);
		valid <= 1; kind <= k; data <= d;
		@(posedge clk);
		valid <= 0;
		fl = 0;
		#1;
		while (hold)
		begin
			fl |= flush;
			@(posedge clk) #1;
		end
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog
	initial
	begin
		#100000;
		n_errors++;
		print_verdict;
	end
	// main sequence
	initial
	begin
		rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		valid = 0; kind = K_NORMAL; data = 0; oi = 1; lck = 0; stb = 0;
		irq = 0;
		repeat (2) @(posedge clk);
		rst <= 0;
		apb(0, A_CTX, 0);
		`CHK("ctx reset", 32'h0000_0000, rd)
		apb(0, 12'h018, 0);
		`CHK("unmapped err", 1'b1, er)
		ins(K_ALT_IMM, 32'h0000_1111);
		`CHK("imm ctx", 32'h0000_1111, actx)
		`CHK("imm no flush", 1'b0, fl)
		ins(K_ALT_DEF, 32'h0000_2222);
		ins(K_NORMAL, 0);
		`CHK("old ctx", 32'h0000_1111, actx)
		ins(K_CSI, 0);
		`CHK("new ctx", 32'h0000_2222, actx)
		`CHK("csi flush", 1'b1, fl)
		ins(K_MSR_WR, 32'h0000_1000);
		apb(0, A_MSR, 0);
		`CHK("msr arch", 32'h0000_1000, rd)
		`CHK("me early", 1'b0, mce)
		`CHK("msr staged view", 32'h0000_0000, amsr)
		ins(K_CSI, 0);
		`CHK("msr view", 32'h0000_1000, amsr)
		ins(K_TLB_OP, 0);
		`CHK("epoch staged", 8'h00, epoch)
		ins(K_MEM_BAR, 0);
		ins(K_TLB_OP, 0);
		ins(K_MEM_BAR, 0);
		ins(K_DBG_WR, 32'h0000_00a5);
		ins(K_CSI, 0);
		`CHK("me late", 1'b1, mce)
		`CHK("epoch seen", 8'h02, epoch)
		`CHK("dbg waits", 32'h0000_0000, dcfg)
		ins(K_MSR_WR, 32'h0000_1200);
		`CHK("dbg commit", 32'h0000_00a5, dcfg)
		apb(1, A_CTRL, 32'h0000_0001);
		ins(K_ALT_IMM, 32'h0000_3333);
		`CHK("strict flush", 1'b1, fl)
		// barrier and drain held by busy core
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			oi <= (i != 2); lck <= (i == 0); stb <= (i == 1);
			fork
				ins(i == 2 ? K_CSI : K_MEM_BAR, 0);
				begin
					repeat (5) @(posedge clk);
					#1 `CHK("held", 1'b1, hold)
					@(posedge clk);
					oi <= 1; lck <= 0; stb <= 0;
				end
			join
		end
		ins(K_ALT_DEF, 32'h0000_4444);
		@(posedge clk);
		irq <= 1;
		#1;
		while (!irq_ack) @(posedge clk) #1;
		`CHK("irq flush", 1'b1, flush)
		`CHK("irq ctx", 32'h0000_4444, actx)
		@(posedge clk);
		irq <= 0;
		print_verdict;
	end
endmodule // tb_cas_seq
`default_nettype wire
